/* rtl/msp_pkg.sv */
// Purpose: Shared constants for the master/slave PWM timer array
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: Offsets are byte addresses; all counts run on the system clock
package msp_pkg;
    localparam int NUM_CH = 8;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Register byte offsets; per-channel arrays step by one word
    localparam logic [7:0] OFS_MODE_BASE = 8'h00;
    localparam logic [7:0] OFS_RELOAD_BASE = 8'h20;
    localparam logic [7:0] OFS_COUNT_BASE = 8'h40;
    localparam logic [7:0] OFS_START = 8'h60;
    localparam logic [7:0] OFS_STOP = 8'h64;
    localparam logic [7:0] OFS_RUNNING = 8'h68;
    localparam logic [7:0] OFS_OUT_VALUE = 8'h6C;
    localparam logic [7:0] OFS_OUT_ENABLE = 8'h70;
    localparam logic [7:0] OFS_OUT_POLARITY = 8'h74;
    localparam logic [7:0] OFS_OUT_ROLE = 8'h78;
    localparam logic [7:0] OFS_PRESCALE = 8'h7C;

    // Field positions inside channel_mode_control
    localparam int MODE_OPT_BIT = 0;
    localparam int MODE_OP_LSB = 1;
    localparam int MODE_EDGE_LSB = 6;
    localparam int MODE_SRC_LSB = 8;
    localparam int MODE_LEADER_BIT = 11;
    localparam int MODE_CCS_BIT = 12;
    localparam int MODE_CKS_LSB = 14;

    // Field codes
    localparam logic [2:0] OP_INTERVAL = 3'h0;
    localparam logic [2:0] OP_ONE_COUNT = 3'h4;
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_MASTER_IRQ = 3'h4;
    localparam logic [1:0] CKS_CLOCK_A = 2'h0;
    localparam logic [1:0] CKS_CLOCK_B = 2'h2;

    // Channels whose leader bit may act, and channels where it is tied low
    localparam logic [7:0] LEADER_CAPABLE = 8'h55;
    localparam logic [7:0] LEADER_FIXED_ZERO = 8'hA0;

    // Reset values
    localparam logic [15:0] RST_MODE = 16'h0000;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [7:0] RST_OUT_REG = 8'h00;
    localparam logic [15:0] RST_PRESCALE = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_LOAD = 2'b01,
        CH_COUNT = 2'b10
    } ch_state_t;
endpackage

/* rtl/msp_channel.sv */
// Purpose: One timer channel: interval or one-count down counter
// Assumes: tick is a one-cycle count clock enable from the prescaler
// Notes: Output level itself is held by the top; this emits set/clear events
`timescale 1ns/1ns
module msp_channel (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Control
    input wire logic i_tick,
    input wire logic [15:0] i_mode,
    input wire logic [15:0] i_reload,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_master_irq,
    // Status and events
    output logic [15:0] o_count,
    output logic o_running,
    output logic o_irq,
    output logic o_set_active,
    output logic o_clear_active
);
    import msp_pkg::*;

    ch_state_t state_q, state_d;
    logic [15:0] count_q, count_d;
    logic running_q, running_d;

    wire [2:0] op_mode = i_mode[MODE_OP_LSB +: 3];
    wire [2:0] src = i_mode[MODE_SRC_LSB +: 3];
    wire opt = i_mode[MODE_OPT_BIT];
    wire is_interval = (op_mode == OP_INTERVAL);
    wire is_one_count = (op_mode == OP_ONE_COUNT);
    wire from_master = is_one_count && (src == SRC_MASTER_IRQ);
    // A slave tied to the master ignores its own software start for loading
    wire sw_trig = i_start && !i_stop && !from_master;
    wire hw_trig = running_q && from_master && i_master_irq;
    // Retrigger while counting: always in interval mode, in one-count mode only when the option bit allows it
    wire accept = (state_q != CH_COUNT) || is_interval || opt;
    wire reload_zero = (i_reload == 16'h0000);

    assign running_d = i_stop ? 1'b0 : (i_start ? 1'b1 : running_q);

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        o_irq = 1'b0;
        o_set_active = 1'b0;
        o_clear_active = 1'b0;
        if (i_stop) begin
            state_d = CH_IDLE;
        end else if ((sw_trig || hw_trig) && accept) begin
            state_d = CH_LOAD;
        end else if (i_tick && running_q) begin
            case (state_q)
                CH_LOAD: begin
                    count_d = i_reload;
                    if (is_interval) begin
                        o_irq = opt;
                        state_d = CH_COUNT;
                    end else if (reload_zero) begin
                        // Zero duty: never goes active
                        o_irq = 1'b1;
                        o_clear_active = 1'b1;
                        state_d = CH_IDLE;
                    end else begin
                        // The load tick is the first active tick, so zero lands on the last one
                        count_d = i_reload - 16'h0001;
                        o_set_active = 1'b1;
                        state_d = CH_COUNT;
                    end
                end
                CH_COUNT: begin
                    if (count_q == 16'h0000) begin
                        o_irq = 1'b1;
                        if (is_interval) begin
                            count_d = i_reload;
                        end else begin
                            o_clear_active = 1'b1;
                            state_d = CH_IDLE;
                        end
                    end else begin
                        count_d = count_q - 16'h0001;
                    end
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            state_q <= CH_IDLE;
            count_q <= 16'h0000;
            running_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            running_q <= running_d;
        end
    end

    assign o_count = count_q;
    assign o_running = running_q;
endmodule

/* rtl/msp_timer_array.sv */
// Purpose: Eight-channel timer array producing master/slave PWM outputs
// Assumes: AXI4-Lite slave, single outstanding read and write
// Notes: Prescaled clocks are count enables derived from the system clock
`timescale 1ns/1ns
// Overview of operation
// - Master mode code zero: reloading interval timer
// - Option bit raises master interrupt at start
// - Source zero: master starts on software trigger
// - Leader bit marks master; fixed zero on 5,7
// - Clock select 00 picks clock A, 10 B
// - Slave mode 100 is one-count operation
// - Option bit accepts retrigger while counting
// - Slave source 100 uses master interrupt trigger
// - Master output disabled, no counting-driven change
// - Role bit one: master sets, terminal clears
// - Polarity zero active-high, one active-low
// - Enable bit lets counting drive the output
// - Disabled: pin shows software value; stopped holds the level
// - Start bits self-clear and set running flags
// - Master reloads and interrupts at zero
// - Slave loads on master interrupt, halts zero
// - Active one tick after trigger, inactive zero
// - Stop clears running, freezes counters, holds outputs
// - Period master plus one; duty slave ratio
// - Slave above master plus one: full duty
// - Channel 0 master drives seven slave waveforms
// - Slave data zero gives zero duty
module msp_timer_array (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // AXI4-Lite write address
    input wire logic [msp_pkg::ADDR_W-1:0] I_AWADDR,
    input wire logic [2:0] I_AWPROT,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // AXI4-Lite write response
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read address
    input wire logic [msp_pkg::ADDR_W-1:0] I_ARADDR,
    input wire logic [2:0] I_ARPROT,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Timer outputs and channel interrupt pulses
    output logic [msp_pkg::NUM_CH-1:0] O_TIMER_OUT,
    output logic [msp_pkg::NUM_CH-1:0] O_CHANNEL_IRQ
);
    import msp_pkg::*;

    // Byte-lane merge for a 16-bit register held in the low half-word
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old_v;
        if (strb[0]) r[7:0] = new_v[7:0];
        if (strb[1]) r[15:8] = new_v[15:8];
        return r;
    endfunction

    // Highest leader-capable channel below ch with its leader bit set, else 0
    function automatic logic [2:0] leader_of(input int ch, input logic [7:0] lead);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 1; i < NUM_CH; i++) begin
            if (i < ch && lead[i]) r = i[2:0];
        end
        return r;
    endfunction

    // Register word decode, shared by read and write paths
    function automatic logic is_array(input logic [7:0] a, input logic [7:0] base);
        return (a[7:5] == base[7:5]);
    endfunction

    // Register state
    logic [15:0] mode_q [NUM_CH];
    logic [15:0] reload_q [NUM_CH];
    logic [7:0] out_value_q;
    logic [7:0] out_enable_q;
    logic [7:0] out_polarity_q;
    logic [7:0] out_role_q;
    logic [15:0] prescale_q;
    logic [7:0] pre_a_q;
    logic [7:0] pre_b_q;
    logic [7:0] irq_q;

    // AXI state
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Channel wires
    logic [15:0] count_w [NUM_CH];
    logic [7:0] running_w;
    logic [7:0] irq_w;
    logic [7:0] set_w;
    logic [7:0] clr_w;
    logic [7:0] tick_w;
    logic [7:0] leader_w;
    logic [7:0] start_w;
    logic [7:0] stop_w;

    // Write channel handshakes
    assign O_AWREADY = !aw_hold_q && !bvalid_q;
    assign O_WREADY = !w_hold_q && !bvalid_q;
    wire aw_take = I_AWVALID && O_AWREADY;
    wire w_take = I_WVALID && O_WREADY;
    wire do_write = aw_hold_q && w_hold_q && !bvalid_q;

    wire [2:0] wr_ch = awaddr_q[4:2];
    wire wr_mode = do_write && is_array(awaddr_q, OFS_MODE_BASE);
    wire wr_reload = do_write && is_array(awaddr_q, OFS_RELOAD_BASE);
    wire wr_count = is_array(awaddr_q, OFS_COUNT_BASE);
    wire wr_start = do_write && (awaddr_q == OFS_START) && wstrb_q[0];
    wire wr_stop = do_write && (awaddr_q == OFS_STOP) && wstrb_q[0];
    wire wr_out_value = do_write && (awaddr_q == OFS_OUT_VALUE) && wstrb_q[0];
    wire wr_out_enable = do_write && (awaddr_q == OFS_OUT_ENABLE) && wstrb_q[0];
    wire wr_out_pol = do_write && (awaddr_q == OFS_OUT_POLARITY) && wstrb_q[0];
    wire wr_out_role = do_write && (awaddr_q == OFS_OUT_ROLE) && wstrb_q[0];
    wire wr_prescale = do_write && (awaddr_q == OFS_PRESCALE);
    wire wr_known = is_array(awaddr_q, OFS_MODE_BASE) || is_array(awaddr_q, OFS_RELOAD_BASE)
        || wr_count || (awaddr_q == OFS_START) || (awaddr_q == OFS_STOP)
        || (awaddr_q == OFS_RUNNING) || (awaddr_q == OFS_OUT_VALUE)
        || (awaddr_q == OFS_OUT_ENABLE) || (awaddr_q == OFS_OUT_POLARITY)
        || (awaddr_q == OFS_OUT_ROLE) || (awaddr_q == OFS_PRESCALE);

    // Trigger registers are never stored, so they read back as zero
    assign start_w = wr_start ? wdata_q[7:0] : 8'h00;
    assign stop_w = wr_stop ? wdata_q[7:0] : 8'h00;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= {I_AWADDR[7:2], 2'b00};
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q <= I_WDATA;
                wstrb_q <= I_WSTRB;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_known && !wr_count) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && I_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign O_BVALID = bvalid_q;
    assign O_BRESP = bresp_q;

    // Read channel
    assign O_ARREADY = !rvalid_q;
    wire ar_take = I_ARVALID && O_ARREADY;
    wire [7:0] ra = {I_ARADDR[7:2], 2'b00};
    wire [2:0] rd_ch = ra[4:2];
    wire rd_mode = is_array(ra, OFS_MODE_BASE);
    wire rd_reload = is_array(ra, OFS_RELOAD_BASE);
    wire rd_count = is_array(ra, OFS_COUNT_BASE);
    wire rd_trig = (ra == OFS_START) || (ra == OFS_STOP);
    wire rd_single = (ra == OFS_RUNNING) || (ra == OFS_OUT_VALUE) || (ra == OFS_OUT_ENABLE)
        || (ra == OFS_OUT_POLARITY) || (ra == OFS_OUT_ROLE) || (ra == OFS_PRESCALE);
    wire rd_known = rd_mode || rd_reload || rd_count || rd_trig || rd_single;
    wire [15:0] rd_val =
        rd_mode ? mode_q[rd_ch] :
        rd_reload ? reload_q[rd_ch] :
        rd_count ? count_w[rd_ch] :
        (ra == OFS_RUNNING) ? {8'h00, running_w} :
        (ra == OFS_OUT_VALUE) ? {8'h00, out_value_q} :
        (ra == OFS_OUT_ENABLE) ? {8'h00, out_enable_q} :
        (ra == OFS_OUT_POLARITY) ? {8'h00, out_polarity_q} :
        (ra == OFS_OUT_ROLE) ? {8'h00, out_role_q} :
        (ra == OFS_PRESCALE) ? prescale_q : 16'h0000;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_val};
            rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign O_RVALID = rvalid_q;
    assign O_RDATA = rdata_q;
    assign O_RRESP = rresp_q;

    // Configuration registers; writes while running are taken as-is
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                mode_q[i] <= RST_MODE;
                reload_q[i] <= RST_RELOAD;
            end
            out_enable_q <= RST_OUT_REG;
            out_polarity_q <= RST_OUT_REG;
            out_role_q <= RST_OUT_REG;
            prescale_q <= RST_PRESCALE;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_mode && wr_ch == i[2:0]) begin
                    mode_q[i] <= merge16(mode_q[i], wdata_q, wstrb_q);
                    if (LEADER_FIXED_ZERO[i]) mode_q[i][MODE_LEADER_BIT] <= 1'b0;
                end
                if (wr_reload && wr_ch == i[2:0]) begin
                    reload_q[i] <= merge16(reload_q[i], wdata_q, wstrb_q);
                end
            end
            if (wr_out_enable) out_enable_q <= wdata_q[7:0];
            if (wr_out_pol) out_polarity_q <= wdata_q[7:0];
            if (wr_out_role) out_role_q <= wdata_q[7:0];
            if (wr_prescale) prescale_q <= merge16(prescale_q, wdata_q, wstrb_q);
        end
    end

    // Two prescaled count enables; divisor N gives one tick every N+1 clocks
    wire tick_a = (pre_a_q == prescale_q[7:0]);
    wire tick_b = (pre_b_q == prescale_q[15:8]);

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            pre_a_q <= 8'h00;
            pre_b_q <= 8'h00;
        end else begin
            pre_a_q <= tick_a ? 8'h00 : pre_a_q + 8'h01;
            pre_b_q <= tick_b ? 8'h00 : pre_b_q + 8'h01;
        end
    end

    // Channels
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        wire [1:0] cks = mode_q[g][MODE_CKS_LSB +: 2];
        // Only the high code bit matters: 00 picks A, 10 picks B
        assign tick_w[g] = (cks[1] == CKS_CLOCK_B[1]) ? tick_b : tick_a;
        assign leader_w[g] = mode_q[g][MODE_LEADER_BIT] && LEADER_CAPABLE[g];
        wire master_irq;
        // Channel 0 has no leader; feeding it its own interrupt would form a loop
        if (g == 0) begin : g_top
            assign master_irq = 1'b0;
        end else begin : g_sub
            assign master_irq = irq_w[leader_of(g, leader_w)];
        end

        msp_channel u_channel (
            .I_CLK_SYS(I_CLK_SYS),
            .I_RST_N(I_RST_N),
            .i_tick(tick_w[g]),
            .i_mode(mode_q[g]),
            .i_reload(reload_q[g]),
            .i_start(start_w[g]),
            .i_stop(stop_w[g]),
            .i_master_irq(master_irq),
            .o_count(count_w[g]),
            .o_running(running_w[g]),
            .o_irq(irq_w[g]),
            .o_set_active(set_w[g]),
            .o_clear_active(clr_w[g])
        );
    end

    // Counting only steers outputs that are enabled and in slave role
    wire [7:0] hw_drive = out_enable_q & out_role_q;
    wire [7:0] active_lvl = ~out_polarity_q;

    // The output register is the pin level; software writes land only on
    // bits whose enable is clear, so a stop simply holds the level
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            out_value_q <= RST_OUT_REG;
            irq_q <= 8'h00;
        end else begin
            irq_q <= irq_w;
            for (int i = 0; i < NUM_CH; i++) begin
                if (hw_drive[i] && set_w[i]) begin
                    out_value_q[i] <= active_lvl[i];
                end else if (hw_drive[i] && clr_w[i]) begin
                    out_value_q[i] <= ~active_lvl[i];
                end else if (wr_out_value && !out_enable_q[i]) begin
                    out_value_q[i] <= wdata_q[i];
                end
            end
        end
    end

    assign O_TIMER_OUT = out_value_q;
    assign O_CHANNEL_IRQ = irq_q;
endmodule

/* verif/msp_monitor.sv */
// Purpose: Port-level checks of the PWM timer array register bus and pins
// Assumes: Sees only top ports; single clock domain
// Notes: Channel 0 is used as master, so its pin moves only on writes
`timescale 1ns/1ns
module msp_monitor (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Bus handshakes
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    // Pins
    input wire logic [7:0] O_TIMER_OUT
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    a_bvalid_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    a_bvalid_drop: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response not retired");
    a_write_latency: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
        else $error("write response late");
    a_no_aw_in_b: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write accepted while response pending");
    a_rvalid_holds: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
        else $error("read data changed before accept");
    a_read_latency: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read data late");
    a_arready_rvalid: assert property (O_ARREADY != O_RVALID)
        else $error("read address ready wrong");
    a_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:16] == 16'h0000)
        else $error("upper read data not zero");
    // Master output mode has no counting-driven change at all
    a_ch0_pin_write: assert property ($changed(O_TIMER_OUT[0]) |-> $rose(O_BVALID))
        else $error("master pin moved without a write");
endmodule
bind msp_timer_array msp_monitor msp_monitor_i (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .O_TIMER_OUT(O_TIMER_OUT));

/* verif/msp_load.sv */
// Purpose: Load on the timer pins: counts high cycles and interrupt pulses
// Assumes: Counts are cleared by the bench before each window
// Notes: Counting over whole periods makes the result phase independent
`timescale 1ns/1ns
module msp_load (
    // Clock
    input wire logic I_CLK_SYS,
    // Window control
    input wire logic i_clr,
    input wire logic i_win,
    // Observed pins
    input wire logic [7:0] i_pins,
    input wire logic [7:0] i_irqs,
    // Results
    output logic [15:0] o_high [8],
    output logic [15:0] o_nirq [8]
);
    always_ff @(posedge I_CLK_SYS) begin
        for (int i = 0; i < 8; i++) begin
            if (i_clr) begin
                o_high[i] <= 16'h0000;
                o_nirq[i] <= 16'h0000;
            end else if (i_win) begin
                o_high[i] <= o_high[i] + {15'h0000, i_pins[i]};
                o_nirq[i] <= o_nirq[i] + {15'h0000, i_irqs[i]};
            end
        end
    end
endmodule

/* verif/tb_top.sv */
// Purpose: Register-driven PWM scenarios on the timer array
// Assumes: Prescale 0 gives a tick every clock
// Notes: Channel 0 master, 1 normal duty, 2 zero duty, 3 full duty active-low
`timescale 1ns/1ns
module tb_top;
    import msp_pkg::*;
    logic I_CLK_SYS = 1'h0, I_RST_N = 1'h0, clr = 1'h0, win = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, pins, irqs;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [15:0] high [8], nirq [8];
    int err_total = 0, comparisons = 0;
    always #50 I_CLK_SYS = ~I_CLK_SYS;
    msp_timer_array msp_timer_array_i (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
        .I_AWADDR(awaddr), .I_AWPROT(3'h0), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARPROT(3'h0), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_TIMER_OUT(pins),
        .O_CHANNEL_IRQ(irqs));
    msp_load msp_load_i (.I_CLK_SYS(I_CLK_SYS), .i_clr(clr), .i_win(win), .i_pins(pins),
        .i_irqs(irqs), .o_high(high), .o_nirq(nirq));
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang;
        err_total++;
        $display("Error at %0t: bus wait timed out", $time);
        report_and_stop();
    endtask
    // Ready is sampled at the falling edge: it cannot move before the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic pa, pw, sa, sw, sb;
        @(posedge I_CLK_SYS);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        pa = 1'h1;
        pw = 1'h1;
        sb = 1'h0;
        n = 0;
        while (!sb && n < 50) begin
            @(negedge I_CLK_SYS);
            sa = awready;
            sw = wready;
            sb = bvalid;
            r = bresp;
            @(posedge I_CLK_SYS);
            if (pa && sa) awvalid <= 1'h0;
            if (pa && sa) pa = 1'h0;
            if (pw && sw) wvalid <= 1'h0;
            if (pw && sw) pw = 1'h0;
            if (sb) bready <= 1'h0;
            n++;
        end
        if (!sb) hang();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic sa, sr;
        @(posedge I_CLK_SYS);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        sr = 1'h0;
        n = 0;
        while (!sr && n < 50) begin
            @(negedge I_CLK_SYS);
            sa = arready;
            sr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge I_CLK_SYS);
            if (sa) arvalid <= 1'h0;
            if (sr) rready <= 1'h0;
            n++;
        end
        if (!sr) hang();
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
    endtask
    initial begin
        logic [31:0] d, c1;
        logic [1:0] r;
        logic [7:0] snap;
        logic [15:0] hs;
        repeat (3) @(posedge I_CLK_SYS);
        I_RST_N <= 1'h1;
        rc(OFS_MODE_BASE + 8'h10, {16'h0000, RST_MODE});
        rd(8'h80, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFS_COUNT_BASE, 32'h1234, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        w(OFS_MODE_BASE + 8'h14, 32'h0800);
        rc(OFS_MODE_BASE + 8'h14, 32'h0000);
        w(OFS_OUT_VALUE, 32'h08);
        w(OFS_OUT_POLARITY, 32'h08);
        w(OFS_OUT_ENABLE, 32'h0E);
        w(OFS_OUT_ROLE, 32'h0E);
        chk({24'h0, pins}, 32'h08);
        w(OFS_RELOAD_BASE, 32'h3);
        w(OFS_RELOAD_BASE + 8'h04, 32'h2);
        w(OFS_RELOAD_BASE + 8'h08, 32'h0);
        w(OFS_RELOAD_BASE + 8'h0C, 32'h5);
        for (int k = 0; k < 2; k++) begin
            hs = (k == 1) ? 16'h8000 : 16'h0000;
            w(OFS_PRESCALE, (k == 1) ? 32'h0100 : 32'h0);
            w(OFS_MODE_BASE, {16'h0000, hs | 16'h0801});
            for (int c = 1; c < 4; c++) begin
                w(OFS_MODE_BASE + 8'(4 * c), {16'h0000, hs | 16'h0409});
            end
            w(OFS_START, 32'h0F);
            rc(OFS_RUNNING, 32'h0F);
            rc(OFS_START, 32'h00);
            repeat (20) @(posedge I_CLK_SYS);
            clr <= 1'h1;
            @(posedge I_CLK_SYS);
            clr <= 1'h0;
            win <= 1'h1;
            repeat (80) @(posedge I_CLK_SYS);
            win <= 1'h0;
            @(posedge I_CLK_SYS);
            chk({16'h0, nirq[0]}, (k == 1) ? 32'h0A : 32'h14);
            chk({16'h0, nirq[1]}, (k == 1) ? 32'h0A : 32'h14);
            chk({16'h0, high[1]}, 32'h28);
            chk({16'h0, high[2]}, 32'h00);
            chk({16'h0, high[3]}, 32'h00);
            chk({16'h0, high[0]}, 32'h00);
            w(OFS_STOP, 32'h0F);
            rc(OFS_RUNNING, 32'h00);
            snap = pins;
            rd(OFS_COUNT_BASE, c1, r);
            repeat (10) @(posedge I_CLK_SYS);
            rc(OFS_COUNT_BASE, c1);
            chk({24'h0, pins}, {24'h0, snap});
        end
        w(OFS_OUT_ENABLE, 32'h00);
        w(OFS_OUT_VALUE, 32'h5B);
        chk({24'h0, pins}, 32'h5B);
        report_and_stop();
    end
endmodule
